// ===== inc/afssp_pkg.sv
// Shared constants and types of the converter's framed serial port.
// Assumes a single 50 MHz system clock; all link pins arrive unsynchronised.
package afssp_pkg;

  localparam int unsigned WORD_BITS      = 24;
  localparam int unsigned CNT_BITS       = 5;
  localparam int unsigned FIFO_DEPTH     = 4;
  localparam int unsigned FIFO_PTR_BITS  = 2;

  // Control word layout, most significant bit sent first
  localparam int unsigned CTRL_MODE_MSB  = 23;
  localparam int unsigned CTRL_MODE_LSB  = 21;
  localparam int unsigned CTRL_CALACC    = 14;
  localparam int unsigned CTRL_BIPOLAR_N = 12;
  localparam logic [WORD_BITS-1:0] CTRL_RESET = 24'h000000;
  localparam logic [2:0] MODE_NORMAL     = 3'h0;

  // Self-clocked serial clock: half period in ns, then in system cycles
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned SCLK_HALF_NS   = 80;
  localparam int unsigned SCLK_HALF_CYC  =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIV_BITS       = 3;

  // Synchronised pin vector positions
  localparam int unsigned PIN_MODE  = 0;
  localparam int unsigned PIN_WFS   = 1;
  localparam int unsigned PIN_RFS   = 2;
  localparam int unsigned PIN_SEL   = 3;
  localparam int unsigned PIN_SCLK  = 4;
  localparam int unsigned PIN_SDI   = 5;
  localparam int unsigned PIN_COUNT = 6;
  // Strobes and the host clock idle high, so no false edge follows reset
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 6'h16;

  typedef enum logic [1:0] {
    AFSSP_IDLE  = 2'h0,
    AFSSP_WRITE = 2'h1,
    AFSSP_READ  = 2'h2,
    AFSSP_DONE  = 2'h3
  } afssp_state_e;

  typedef enum logic [1:0] {
    AFSSP_SRC_CTRL   = 2'h0,
    AFSSP_SRC_RESULT = 2'h1,
    AFSSP_SRC_CAL    = 2'h2,
    AFSSP_SRC_NONE   = 2'h3
  } afssp_src_e;

  // Raw conversion result, two's complement from the filter
  typedef struct packed {
    logic [WORD_BITS-1:0] value;
  } afssp_conv_s;

endpackage

// ===== rtl/afssp_port.sv
// Framed bidirectional serial port of the converter, plus its result FIFO.
// Assumes the host drives the frame strobes and, in external clocking,
// the serial clock; every link pin is sampled by the 50 MHz system clock.
//
// Behaviour
// - Write strobe is active low; write bits are taken only after it falls.
// - Self-clocked, our clock starts only after the write strobe falls.
// - Read strobe, active low: self-clocked, clock and data follow its fall.
// - Host-clocked, data is driven only after the read strobe falls.
// - Result ready falls whenever a new conversion word is available.
// - Result ready returns high once a full word has been shifted out.
// - Result ready also falls when a calibration sequence finishes.
// - A result read is driven only while result ready is low.
// - Write bits are sampled on rising clock edges while its strobe is low.
// - Results are natural binary if unipolar, offset binary if bipolar.
// - The line writes control or calibration, and reads those or results.
// - Bipolar midscale lies between 0111...111 and 1000...000.
// - Control loads only after 24 bits; clocks past the 24th are ignored.
`timescale 1ns/10ps
`default_nettype none

module afssp_fifo #(
  parameter int unsigned WIDTH    = afssp_pkg::WORD_BITS,
  parameter int unsigned DEPTH    = afssp_pkg::FIFO_DEPTH,
  parameter int unsigned PTR_BITS = afssp_pkg::FIFO_PTR_BITS
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0]  mem_q [DEPTH];
  logic [PTR_BITS-1:0] wr_q;
  logic [PTR_BITS-1:0] rd_q;
  logic [PTR_BITS:0]   cnt_q;
  logic [PTR_BITS:0]   cnt_d;
  wire               push = in_valid && in_ready;
  wire               pop  = out_valid && out_ready;

  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign cnt_d     = cnt_q + (PTR_BITS+1)'(push) - (PTR_BITS+1)'(pop);

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q     <= '0;
      rd_q     <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_q     <= wr_q + PTR_BITS'(push);
      rd_q     <= rd_q + PTR_BITS'(pop);
      cnt_q    <= cnt_d;
      // Registered so the source sees back-pressure without a comb path
      in_ready <= (cnt_d != (PTR_BITS+1)'(DEPTH));
    end
  end
endmodule

module afssp_port (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clock_mode_self,
  input  wire logic                 write_frame_strobe_n,
  input  wire logic                 read_frame_strobe_n,
  input  wire logic                 register_select,
  input  wire logic                 serial_clock_i,
  output logic                      serial_clock_o,
  output logic                      serial_clock_oe,
  input  wire logic                 shared_serial_line_i,
  output logic                      shared_serial_line_o,
  output logic                      shared_serial_line_oe,
  output logic                      result_ready_n,
  input  wire logic                 conv_valid,
  output logic                      conv_ready,
  input  wire afssp_pkg::afssp_conv_s conv_data,
  input  wire logic                 cal_done,
  output logic                      cal_start,
  output logic [afssp_pkg::WORD_BITS-1:0] ctrl_word
);
  localparam int unsigned W = afssp_pkg::WORD_BITS;
  localparam int unsigned N = afssp_pkg::PIN_COUNT;
  localparam int unsigned C = afssp_pkg::CNT_BITS;
  localparam int unsigned D = afssp_pkg::DIV_BITS;
  // Three-stage sampling; a level is accepted when stages two and three agree
  logic [N-1:0] s1_q;
  logic [N-1:0] s2_q;
  logic [N-1:0] s3_q;
  logic [N-1:0] pin_q;
  wire  [N-1:0] pin_raw = {shared_serial_line_i, serial_clock_i,
                           register_select, read_frame_strobe_n,
                           write_frame_strobe_n, clock_mode_self};

  for (genvar i = 0; i < N; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        s1_q[i]  <= afssp_pkg::PIN_RESET[i];
        s2_q[i]  <= afssp_pkg::PIN_RESET[i];
        s3_q[i]  <= afssp_pkg::PIN_RESET[i];
        pin_q[i] <= afssp_pkg::PIN_RESET[i];
      end else begin
        s1_q[i]  <= pin_raw[i];
        s2_q[i]  <= s1_q[i];
        s3_q[i]  <= s2_q[i];
        pin_q[i] <= (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
      end
    end
  end
  function automatic logic [W-1:0] encode(input logic [W-1:0] raw,
                                          input logic bipolar);
    logic [W-1:0] r;
    r = raw;
    if (bipolar) begin
      r[W-1] = ~raw[W-1];
    end else if (raw[W-1]) begin
      r = '0;
    end
    return r;
  endfunction
  afssp_pkg::afssp_state_e state_q;
  afssp_pkg::afssp_src_e   src_q;
  logic [W-1:0] ctrl_q;
  logic [W-1:0] cal_q [2];
  logic         cal_ptr_q;
  logic [W-1:0] sh_q;
  logic [C-1:0] bits_q;
  logic [D-1:0] div_q;
  logic         sclk_q;
  logic         sclk_prev_q;
  logic         sdo_q;
  logic         sdo_oe_q;
  logic         sclk_oe_q;
  logic         rdy_n_q;
  logic         cal_flag_q;
  logic         gap_q;
  logic         cal_start_q;
  wire self_mode = pin_q[afssp_pkg::PIN_MODE];
  wire wfs_low   = ~pin_q[afssp_pkg::PIN_WFS];
  wire rfs_low   = ~pin_q[afssp_pkg::PIN_RFS];
  wire sel_ctrl  = ~pin_q[afssp_pkg::PIN_SEL];
  wire bipolar   = ~ctrl_q[afssp_pkg::CTRL_BIPOLAR_N];
  wire cal_acc   = ctrl_q[afssp_pkg::CTRL_CALACC];
  wire word_done = (bits_q == C'(W));
  wire active    = (state_q == afssp_pkg::AFSSP_WRITE) ||
                   (state_q == afssp_pkg::AFSSP_READ);
  // Self-clocked edges come from our own divider, external ones from the pin
  wire div_wrap  = (div_q == D'(afssp_pkg::SCLK_HALF_CYC - 1));
  wire gen_run   = self_mode && active && !word_done;
  wire ext_level = pin_q[afssp_pkg::PIN_SCLK];
  wire sclk_rise = self_mode ? (gen_run && div_wrap && !sclk_q)
                             : (ext_level && !sclk_prev_q);
  wire sclk_fall = self_mode ? (gen_run && div_wrap && sclk_q)
                             : (!ext_level && sclk_prev_q);
  wire fifo_valid;
  wire [W-1:0] fifo_data;
  wire result_avail = fifo_valid || cal_flag_q;
  wire rd_done      = (state_q == afssp_pkg::AFSSP_READ) && word_done;
  wire fifo_pop     = rd_done && (src_q == afssp_pkg::AFSSP_SRC_RESULT);
  // Read word selection (control, result or calibration) at the read strobe's fall
  wire afssp_pkg::afssp_src_e rd_src =
    sel_ctrl ? afssp_pkg::AFSSP_SRC_CTRL :
    (!rdy_n_q && fifo_valid) ? afssp_pkg::AFSSP_SRC_RESULT :
    cal_acc ? afssp_pkg::AFSSP_SRC_CAL : afssp_pkg::AFSSP_SRC_NONE;
  wire [W-1:0] rd_word =
    (rd_src == afssp_pkg::AFSSP_SRC_CTRL)   ? ctrl_q :
    (rd_src == afssp_pkg::AFSSP_SRC_RESULT) ? encode(fifo_data, bipolar) :
    cal_q[cal_ptr_q];
  wire start_rd = (state_q == afssp_pkg::AFSSP_IDLE) && rfs_low &&
                  !wfs_low;
  wire start_wr = (state_q == afssp_pkg::AFSSP_IDLE) && wfs_low;
  // Write completes only when the strobe rises after a full 24-bit word
  wire wr_end   = (state_q == afssp_pkg::AFSSP_WRITE) && !wfs_low;
  wire wr_load  = wr_end && word_done;
  wire ctrl_ld  = wr_load && (src_q == afssp_pkg::AFSSP_SRC_CTRL);
  wire cal_ld   = wr_load && (src_q == afssp_pkg::AFSSP_SRC_CAL);
  wire cal_go   = ctrl_ld && (sh_q[afssp_pkg::CTRL_MODE_MSB:
                                   afssp_pkg::CTRL_MODE_LSB] !=
                              afssp_pkg::MODE_NORMAL);
  afssp_fifo #(
    .WIDTH    (W),
    .DEPTH    (afssp_pkg::FIFO_DEPTH),
    .PTR_BITS (afssp_pkg::FIFO_PTR_BITS)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .in_data   (conv_data.value),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= afssp_pkg::AFSSP_IDLE;
      src_q   <= afssp_pkg::AFSSP_SRC_NONE;
    end else begin
      case (state_q)
        afssp_pkg::AFSSP_IDLE: begin
          if (start_wr) begin
            state_q <= afssp_pkg::AFSSP_WRITE;
            src_q   <= sel_ctrl ? afssp_pkg::AFSSP_SRC_CTRL :
                       cal_acc ? afssp_pkg::AFSSP_SRC_CAL :
                       afssp_pkg::AFSSP_SRC_NONE;
          end else if (start_rd) begin
            state_q <= afssp_pkg::AFSSP_READ;
            src_q   <= rd_src;
          end
        end
        afssp_pkg::AFSSP_WRITE: begin
          if (!wfs_low) begin
            state_q <= afssp_pkg::AFSSP_DONE;
          end
        end
        afssp_pkg::AFSSP_READ: begin
          if (!rfs_low || word_done) begin
            state_q <= afssp_pkg::AFSSP_DONE;
          end
        end
        afssp_pkg::AFSSP_DONE: begin
          if (!wfs_low && !rfs_low) begin
            state_q <= afssp_pkg::AFSSP_IDLE;
          end
        end
        default: state_q <= afssp_pkg::AFSSP_IDLE;
      endcase
    end
  end
  // Shared shifter; reads shift only after a rise, keeping the MSB up first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bits_q <= '0;
      sh_q   <= '0;
    end else if (start_wr) begin
      bits_q <= '0;
    end else if (start_rd) begin
      bits_q <= '0;
      sh_q   <= rd_word;
    end else if (state_q == afssp_pkg::AFSSP_WRITE && wfs_low &&
                 sclk_rise && !word_done) begin
      bits_q <= bits_q + C'(1);
      sh_q   <= {sh_q[W-2:0], pin_q[afssp_pkg::PIN_SDI]};
    end else if (state_q == afssp_pkg::AFSSP_READ && sclk_rise &&
                 !word_done) begin
      bits_q <= bits_q + C'(1);
    end else if (state_q == afssp_pkg::AFSSP_READ && sclk_fall && |bits_q) begin
      sh_q   <= {sh_q[W-2:0], 1'b0};
    end
  end
  // Serial clock generator and pin drivers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q       <= '0;
      sclk_q      <= 1'b1;
      sclk_prev_q <= 1'b1;
      sclk_oe_q   <= 1'b0;
    end else begin
      div_q       <= (gen_run && !div_wrap) ? div_q + D'(1) : '0;
      sclk_q      <= (gen_run && div_wrap) ? ~sclk_q : (sclk_q | ~gen_run);
      sclk_prev_q <= self_mode ? sclk_q : ext_level;
      sclk_oe_q   <= self_mode && active;
    end
  end
  // Data drives only while a readable word is being shifted out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_q    <= sh_q[W-1];
      sdo_oe_q <= (state_q == afssp_pkg::AFSSP_READ) && rfs_low &&
                  (src_q != afssp_pkg::AFSSP_SRC_NONE);
    end
  end
  // Registers loaded from the link, and calibration handshake
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q      <= afssp_pkg::CTRL_RESET;
      cal_q[0]    <= '0;
      cal_q[1]    <= '0;
      cal_ptr_q   <= 1'b0;
      cal_start_q <= 1'b0;
    end else begin
      cal_start_q <= cal_go;
      if (ctrl_ld) begin
        ctrl_q <= sh_q;
      end else if (cal_done) begin
        ctrl_q[afssp_pkg::CTRL_MODE_MSB:afssp_pkg::CTRL_MODE_LSB] <=
          afssp_pkg::MODE_NORMAL;
      end
      if (cal_ld) begin
        cal_q[cal_ptr_q] <= sh_q;
      end
      if (cal_ld || (rd_done && src_q == afssp_pkg::AFSSP_SRC_CAL)) begin
        cal_ptr_q <= ~cal_ptr_q;
      end
    end
  end

  // Ready goes high for two cycles after each word so every new word
  // shows a fresh falling edge, even when the FIFO still holds more.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cal_flag_q <= 1'b0;
      gap_q      <= 1'b0;
      rdy_n_q    <= 1'b1;
    end else begin
      cal_flag_q <= cal_done || (cal_flag_q && !rd_done);
      gap_q      <= rd_done && !rdy_n_q;
      rdy_n_q    <= !result_avail || gap_q ||
                    (rd_done && !rdy_n_q);
    end
  end

  assign serial_clock_o        = sclk_q;
  assign serial_clock_oe       = sclk_oe_q;
  assign shared_serial_line_o  = sdo_q;
  assign shared_serial_line_oe = sdo_oe_q;
  assign result_ready_n        = rdy_n_q;
  assign cal_start             = cal_start_q;
  assign ctrl_word             = ctrl_q;
endmodule

`default_nettype wire

// ===== verif/afssp_port_checker.sv
// Concurrent checks on the framed serial port's pins and side ports.
// Assumes it is bound into afssp_port and sees only its top-level ports.
`timescale 1ns/10ps
`default_nettype none

module afssp_port_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        clock_mode_self,
  input wire logic        write_frame_strobe_n,
  input wire logic        read_frame_strobe_n,
  input wire logic        register_select,
  input wire logic        serial_clock_o,
  input wire logic        serial_clock_oe,
  input wire logic        shared_serial_line_oe,
  input wire logic        result_ready_n,
  input wire logic        conv_valid,
  input wire logic        conv_ready,
  input wire logic        cal_done,
  input wire logic [23:0] ctrl_word
);
  wire logic any_fs;
  wire logic idle_pins;

  assign any_fs    = !write_frame_strobe_n || !read_frame_strobe_n;
  assign idle_pins = write_frame_strobe_n && read_frame_strobe_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_SCLK_SELF: assert property ($rose(serial_clock_oe) |->
    clock_mode_self && any_fs && $past(any_fs, 2))
    else $error("device clock enabled outside a self-clocked frame");
  AST_DATA_RFS: assert property ($rose(shared_serial_line_oe) |->
    !read_frame_strobe_n && !$past(read_frame_strobe_n, 2))
    else $error("data line driven before read strobe fell");
  AST_RESULT_GATE: assert property ($rose(shared_serial_line_oe) &&
    register_select && !ctrl_word[14] |-> !result_ready_n)
    else $error("result driven while result ready was high");
  AST_SCLK_HALF: assert property ($fell(serial_clock_o) |->
    (!serial_clock_o)[*4] ##1 serial_clock_o)
    else $error("device clock low phase not four cycles");
  AST_RDY_NEW: assert property (conv_valid && conv_ready &&
    idle_pins |-> ##[1:8] !result_ready_n)
    else $error("result ready did not fall for a new word");
  AST_CAL_RDY: assert property (cal_done && idle_pins |->
    ##[1:8] !result_ready_n)
    else $error("result ready did not fall after calibration");
  AST_RDY_RISE: assert property ($rose(result_ready_n) |->
    !read_frame_strobe_n)
    else $error("result ready rose outside a read frame");
  AST_CTRL_LOAD: assert property ($changed(ctrl_word[20:0]) |->
    write_frame_strobe_n && $past(write_frame_strobe_n, 2))
    else $error("control word changed inside a write frame");
  AST_RELEASE: assert property ($rose(read_frame_strobe_n) &&
    write_frame_strobe_n |-> ##[1:8] !shared_serial_line_oe)
    else $error("data line still driven after frame end");

  CV_SELF_CLOCK: cover property ($rose(serial_clock_oe));
  CV_RESULT_READ: cover property ($rose(shared_serial_line_oe) &&
    register_select);
  CV_READY: cover property ($fell(result_ready_n));
endmodule

bind afssp_port afssp_port_checker i_chk (
  .clk                   (clk),
  .sys_rst               (sys_rst),
  .clock_mode_self       (clock_mode_self),
  .write_frame_strobe_n  (write_frame_strobe_n),
  .read_frame_strobe_n   (read_frame_strobe_n),
  .register_select       (register_select),
  .serial_clock_o        (serial_clock_o),
  .serial_clock_oe       (serial_clock_oe),
  .shared_serial_line_oe (shared_serial_line_oe),
  .result_ready_n        (result_ready_n),
  .conv_valid            (conv_valid),
  .conv_ready            (conv_ready),
  .cal_done              (cal_done),
  .ctrl_word             (ctrl_word)
);
`default_nettype wire

// ===== verif/afssp_host_model.sv
// Host serial port: frame strobes, register select, clock and data line.
// Assumes the bench holds the mode pin static within each frame.
`timescale 1ns/10ps
`default_nettype none

module afssp_host_model (
  input  wire logic clk,
  input  wire logic mode_self,
  input  wire logic dev_sclk,
  input  wire logic dev_sclk_oe,
  input  wire logic dev_sd,
  input  wire logic dev_sd_oe,
  output var  logic wfs_n,
  output var  logic rfs_n,
  output var  logic sel,
  output logic      sclk_line,
  output logic      sd_line
);
  logic host_sclk = 1'b1;
  logic host_sd   = 1'b0;
  logic host_oe   = 1'b0;
  logic flip      = 1'b0;
  int   to_cnt    = 0;

  initial begin
    wfs_n = 1'b1;
    rfs_n = 1'b1;
    sel = 1'b0;
  end
  // A released line toggles so a stale level never passes for data
  always @(posedge clk) flip <= ~flip;
  assign sclk_line = dev_sclk_oe ? dev_sclk : host_sclk;
  assign sd_line = dev_sd_oe ? dev_sd : (host_oe ? host_sd : flip);

  // Self mode follows the device clock, external mode makes it
  task automatic edge_to(input logic v);
    int n;
    if (mode_self) begin
      for (n = 0; n < 40 && sclk_line !== v; n++) @(negedge clk);
      if (n == 40) to_cnt++;
    end else begin
      host_sclk = v;
      repeat (4) @(negedge clk);
    end
  endtask

  task automatic send(input logic [23:0] w, input logic s, input int nb);
    int i;
    sel = s;
    wfs_n = 1'b0;
    host_oe = 1'b1;
    repeat (3) @(negedge clk);
    for (i = 0; i < nb; i++) begin
      host_sd = (i < 24) ? w[23-i] : 1'b0;
      edge_to(1'b0);
      edge_to(1'b1);
    end
    repeat (4) @(negedge clk);
    wfs_n = 1'b1;
    host_oe = 1'b0;
    repeat (12) @(negedge clk);
  endtask

  task automatic fetch(input logic s, output logic [23:0] w,
                       output logic drove);
    int i;
    sel = s;
    w = 24'h000000;
    drove = 1'b0;
    rfs_n = 1'b0;
    repeat (3) @(negedge clk);
    for (i = 0; i < 24; i++) begin
      edge_to(1'b0);
      edge_to(1'b1);
      drove = drove | (dev_sd_oe === 1'b1);
      w = {w[22:0], sd_line};
    end
    repeat (4) @(negedge clk);
    rfs_n = 1'b1;
    repeat (12) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_afssp_port.sv
// Bench of the framed serial port: host model on the link, conversion
// words and calibration pulses from here. Assumes a 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module tb_afssp_port;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mode = 1'b0;
  logic conv_valid = 1'b0;
  logic cal_done = 1'b0;
  logic saw_cal = 1'b0;
  afssp_pkg::afssp_conv_s conv_data;
  logic wfs_n, rfs_n, sel, sclk_line, sd_line, drove;
  logic sclk_o, sclk_oe, sd_o, sd_oe, rdy_n, conv_ready, cal_start;
  logic [23:0] ctrl_word;
  logic [23:0] rd;
  int error_cnt = 0;
  int checks_done = 0;

  always #10 clk = ~clk;
  always @(posedge clk) if (cal_start === 1'b1) saw_cal <= 1'b1;

  afssp_port i_dut (.clk(clk), .sys_rst(sys_rst),
    .clock_mode_self(mode), .write_frame_strobe_n(wfs_n),
    .read_frame_strobe_n(rfs_n), .register_select(sel),
    .serial_clock_i(sclk_line), .serial_clock_o(sclk_o),
    .serial_clock_oe(sclk_oe), .shared_serial_line_i(sd_line),
    .shared_serial_line_o(sd_o), .shared_serial_line_oe(sd_oe),
    .result_ready_n(rdy_n), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .conv_data(conv_data),
    .cal_done(cal_done), .cal_start(cal_start), .ctrl_word(ctrl_word));
  afssp_host_model i_host (.clk(clk), .mode_self(mode),
    .dev_sclk(sclk_o), .dev_sclk_oe(sclk_oe), .dev_sd(sd_o),
    .dev_sd_oe(sd_oe), .wfs_n(wfs_n), .rfs_n(rfs_n), .sel(sel),
    .sclk_line(sclk_line), .sd_line(sd_line));

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_w(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_b(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  // A stuck link clock wait ends the run rather than hanging it
  task automatic fin(input string nm);
    if (i_host.to_cnt != 0) begin
      error_cnt++;
      print_verdict();
    end else begin
      $display("Test %s done", nm);
    end
  endtask

  task automatic push(input logic [23:0] w);
    int n;
    @(negedge clk);
    conv_valid = 1'b1;
    conv_data.value = w;
    for (n = 0; n < 50 && conv_ready !== 1'b1; n++) @(negedge clk);
    if (n == 50) begin
      error_cnt++;
      print_verdict();
    end else begin
      @(negedge clk);
      conv_valid = 1'b0;
    end
  endtask

  task automatic t_reset();
    chk_b("result ready", 1'b1, rdy_n);
    chk_b("data enable", 1'b0, sd_oe);
    chk_b("clock enable", 1'b0, sclk_oe);
    chk_w("control", 24'h000000, ctrl_word);
    fin("reset");
  endtask

  task automatic t_write_ext();
    i_host.send(24'h1c6b3d, 1'b0, 24);
    chk_w("control", 24'h1c6b3d, ctrl_word);
    i_host.send(24'h0f0f0f, 1'b0, 20);
    chk_w("short write", 24'h1c6b3d, ctrl_word);
    i_host.send(24'h123456, 1'b0, 30);
    chk_w("long write", 24'h123456, ctrl_word);
    mode = 1'b1;
    i_host.fetch(1'b0, rd, drove);
    chk_w("control read", 24'h123456, rd);
    fin("control");
  endtask

  // Four words fill the buffer while the host stalls, then drain
  task automatic t_bipolar();
    logic [23:0] w [4];
    int i;
    w = '{24'h000000, 24'h7fffff, 24'h800000, 24'hffffff};
    mode = 1'b0;
    i_host.send(24'h000000, 1'b0, 24);
    for (i = 0; i < 4; i++) push(w[i]);
    @(negedge clk);
    chk_b("buffer full", 1'b0, conv_ready);
    chk_b("result ready", 1'b0, rdy_n);
    for (i = 0; i < 4; i++) begin
      i_host.fetch(1'b1, rd, drove);
      chk_w("bipolar", {~w[i][23], w[i][22:0]}, rd);
      chk_b("result driven", 1'b1, drove);
    end
    chk_b("ready after drain", 1'b1, rdy_n);
    fin("bipolar");
  endtask

  task automatic t_unipolar();
    i_host.send(24'h001000, 1'b0, 24);
    mode = 1'b1;
    push(24'h123456);
    push(24'hfffffe);
    i_host.fetch(1'b1, rd, drove);
    chk_w("unipolar", 24'h123456, rd);
    i_host.fetch(1'b1, rd, drove);
    chk_w("clamped", 24'h000000, rd);
    i_host.fetch(1'b1, rd, drove);
    chk_b("refused drive", 1'b0, drove);
    fin("unipolar");
  endtask

  task automatic t_cal();
    i_host.send(24'h201000, 1'b0, 24);
    chk_b("calibration start", 1'b1, saw_cal);
    cal_done = 1'b1;
    @(negedge clk);
    cal_done = 1'b0;
    repeat (4) @(negedge clk);
    chk_b("calibration ready", 1'b0, rdy_n);
    chk_w("mode cleared", 24'h001000, ctrl_word);
    i_host.fetch(1'b0, rd, drove);
    chk_w("control after cal", 24'h001000, rd);
    chk_b("ready after read", 1'b1, rdy_n);
    fin("calibration");
  endtask

  initial begin
    conv_data.value = 24'h000000;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    t_reset();
    t_write_ext();
    t_bipolar();
    t_unipolar();
    t_cal();
    print_verdict();
  end
endmodule
`default_nettype wire
